// >>> scl_crc8.sv
/*
 * Running CRC-8 over the configuration words ahead of the checksum word.
 * Assumes words arrive low byte first in memory order, one per strobe.
 */
`timescale 1ns/1ps
module scl_crc8
	import scl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Word stream
	input wire logic word_valid,
	input wire logic [4:0] word_idx,
	input wire logic [15:0] word_data,
	// Result
	output logic [7:0] crc_value
);
	logic [7:0] crc_reg; // Running value

	// Fold both bytes of each word preceding the checksum
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_reg <= CRC_INIT;
		end else if (word_valid && (word_idx < FIDX_CHECKSUM)) begin
			crc_reg <= crc8_byte(crc8_byte(crc_reg, word_data[7:0]), word_data[15:8]);
		end
	end

	assign crc_value = crc_reg;
endmodule // scl_crc8

// >>> scl_loader.sv
/*
 * Power-up configuration loader with its AXI4-Lite register file.
 * Assumes a word-addressed memory read port and a single synchronous clock domain.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - Alias word 0004h loads alias register automatically.
// - Alias reloads only after next power cycle.
// - Word 0007h holds configuration area checksum.
// - Word 0000h seeds host interface control.
// - Word 0001h seeds host interface configuration.
// - Configuration area seeds SYNC pulse length.
// - Configuration area seeds extended host configuration.
// - Bootstrap receive mailbox 1000h, size 0100h.
// - Default receive mailbox 1000h, size 0100h.
// - Default send mailbox 1200h, size 0100h.
// - Word 003Eh holds size code 000Fh.
// - Memory addressed in 16-bit words only.
module scl_loader
	import scl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [15:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [15:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Information memory read port
	output logic mem_rd_req,
	output logic [9:0] mem_rd_addr,
	input wire logic mem_rd_ack,
	input wire logic [15:0] mem_rd_data,
	// Configuration values to the controller
	output logic [15:0] station_alias,
	output logic [15:0] host_iface_control,
	output logic [15:0] host_iface_config,
	output logic [15:0] host_iface_ext_config,
	output logic [15:0] sync_pulse_length,
	output logic config_loaded
);

	// Loader sequence
	typedef enum logic [2:0] {
		LD_FETCH = 3'b001,
		LD_APPLY = 3'b010,
		LD_DONE = 3'b100
	} scl_state_t;

	scl_state_t state_reg; // Current step
	scl_state_t state_next; // Next step

	// Word stream from the fetcher
	logic word_valid; // One-cycle strobe
	logic [4:0] word_idx; // Fetch step of word
	logic [15:0] word_data; // Word content
	logic fetch_done; // All words read
	logic [7:0] crc_value; // Computed checksum

	// Staging and verdicts
	logic [15:0] stage_reg [0:4]; // Words 0..4 before release
	logic [15:0] stored_sum_reg; // Checksum word as stored
	logic layout_bad_reg; // Any layout word off
	logic crc_ok; // Computed matches stored
	logic crc_ok_reg; // Verdict kept for status

	// Live registers, indexed by slot
	logic [15:0] cfg_reg [0:4];

	// AXI state
	logic aw_hold_reg; // Write address taken
	logic [15:0] aw_addr_reg; // Held write address
	logic w_hold_reg; // Write data taken
	logic [31:0] w_data_reg; // Held write data
	logic [3:0] w_strb_reg; // Held byte enables
	logic bvalid_reg; // Response pending
	logic [1:0] bresp_reg; // Response code
	logic rvalid_reg; // Read data pending
	logic [31:0] rdata_reg; // Read data
	logic [1:0] rresp_reg; // Read response
	logic [2:0] wr_slot; // Decoded write target
	logic [2:0] rd_slot; // Decoded read target
	logic [15:0] status_word; // Loader status view

	// Hardware default of a slot
	function automatic logic [15:0] reset_val(input int unsigned slot);
		case (slot)
			0: return RST_HOST_CTRL;
			1: return RST_HOST_CFG;
			2: return RST_SYNC_PULSE;
			3: return RST_HOST_EXT_CFG;
			default: return RST_STATION_ALIAS;
		endcase
	endfunction

	// Byte address to slot; non-word-aligned or unknown gives none
	function automatic logic [2:0] decode_slot(input logic [15:0] addr);
		if (addr[1:0] != 2'h0) begin
			return SLOT_NONE;
		end else if (addr[15:2] == {2'h0, IDX_HOST_CTRL}) begin
			return SLOT_HOST_CTRL;
		end else if (addr[15:2] == {2'h0, IDX_HOST_CFG}) begin
			return SLOT_HOST_CFG;
		end else if (addr[15:2] == {2'h0, IDX_SYNC_PULSE}) begin
			return SLOT_SYNC_PULSE;
		end else if (addr[15:2] == {2'h0, IDX_HOST_EXT_CFG}) begin
			return SLOT_HOST_EXT_CFG;
		end else if (addr[15:2] == {2'h0, IDX_STATION_ALIAS}) begin
			return SLOT_STATION_ALIAS;
		end else if (addr[15:2] == {2'h0, IDX_LOAD_STATUS}) begin
			return SLOT_STATUS;
		end else begin
			return SLOT_NONE;
		end
	endfunction

	// Fetch sequencer
	scl_word_fetch u_fetch (
		.aclk(aclk),
		.aresetn(aresetn),
		.mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr),
		.mem_rd_ack(mem_rd_ack),
		.mem_rd_data(mem_rd_data),
		.word_valid(word_valid),
		.word_idx(word_idx),
		.word_data(word_data),
		.fetch_done(fetch_done)
	);

	// Checksum engine
	scl_crc8 u_crc (
		.aclk(aclk),
		.aresetn(aresetn),
		.word_valid(word_valid),
		.word_idx(word_idx),
		.word_data(word_data),
		.crc_value(crc_value)
	);

	// Only the low byte carries the CRC; high byte is not checked
	assign crc_ok = (crc_value == stored_sum_reg[7:0]);

	// Step logic: apply once, then stay done until the next reset
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LD_FETCH: begin
				if (fetch_done) begin
					state_next = LD_APPLY;
				end
			end
			LD_APPLY: begin
				state_next = LD_DONE;
			end
			LD_DONE: begin
				state_next = LD_DONE;
			end
			default: begin
				state_next = LD_FETCH;
			end
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= LD_FETCH;
		end else begin
			state_reg <= state_next;
		end
	end

	// Staging of words 0..4; nothing reaches the outputs yet
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 5; i++) begin
				stage_reg[i] <= 16'h0000;
			end
		end else if (word_valid && (word_idx <= {2'h0, SLOT_STATION_ALIAS})) begin
			stage_reg[word_idx[2:0]] <= word_data;
		end
	end

	// Stored checksum word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stored_sum_reg <= 16'h0000;
		end else if (word_valid && (word_idx == FIDX_CHECKSUM)) begin
			stored_sum_reg <= word_data;
		end
	end

	// Layout check of mailbox and size words; only reported, never gates loading
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			layout_bad_reg <= 1'b0;
		end else if (word_valid && (word_idx >= FIDX_MBX_FIRST)) begin
			if (word_data != expected_word(word_idx)) begin
				layout_bad_reg <= 1'b1;
			end
		end
	end

	// Checksum verdict kept for the status register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_ok_reg <= 1'b0;
		end else if (state_reg == LD_APPLY) begin
			crc_ok_reg <= crc_ok;
		end
	end

	// Write address channel; taken once, held until the write is done
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 16'h0000;
		end else if (awvalid && awready) begin
			aw_hold_reg <= 1'b1;
			aw_addr_reg <= awaddr;
		end else if (aw_hold_reg && w_hold_reg) begin
			aw_hold_reg <= 1'b0;
		end
	end

	// Write data channel, independent of the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (wvalid && wready) begin
			w_hold_reg <= 1'b1;
			w_data_reg <= wdata;
			w_strb_reg <= wstrb;
		end else if (aw_hold_reg && w_hold_reg) begin
			w_hold_reg <= 1'b0;
		end
	end

	assign awready = !aw_hold_reg && !bvalid_reg;
	assign wready = !w_hold_reg && !bvalid_reg;
	assign wr_slot = decode_slot(aw_addr_reg);

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (aw_hold_reg && w_hold_reg) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_slot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid_reg && bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Live registers: defaults until apply, image on good checksum, then software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 5; i++) begin
				cfg_reg[i] <= reset_val(i);
			end
		end else if (state_reg == LD_APPLY) begin
			if (crc_ok) begin
				cfg_reg[SLOT_HOST_CTRL] <= stage_reg[SLOT_HOST_CTRL];
				cfg_reg[SLOT_HOST_CFG] <= stage_reg[SLOT_HOST_CFG];
				cfg_reg[SLOT_SYNC_PULSE] <= stage_reg[SLOT_SYNC_PULSE];
				cfg_reg[SLOT_HOST_EXT_CFG] <= stage_reg[SLOT_HOST_EXT_CFG];
				cfg_reg[SLOT_STATION_ALIAS] <= stage_reg[SLOT_STATION_ALIAS];
			end
		end else if ((state_reg == LD_DONE) && aw_hold_reg && w_hold_reg && (wr_slot <= SLOT_STATION_ALIAS)) begin
			// Software writes are ignored while loading, so the image cannot be torn
			if (w_strb_reg[0]) begin
				cfg_reg[wr_slot][7:0] <= w_data_reg[7:0];
			end
			if (w_strb_reg[1]) begin
				cfg_reg[wr_slot][15:8] <= w_data_reg[15:8];
			end
		end
	end

	// Status view of the loader
	always_comb begin
		status_word = 16'h0000;
		status_word[ST_DONE_BIT] = (state_reg == LD_DONE);
		status_word[ST_CRC_OK_BIT] = crc_ok_reg;
		status_word[ST_LAYOUT_OK_BIT] = (state_reg == LD_DONE) && !layout_bad_reg;
		status_word[ST_BUSY_BIT] = (state_reg != LD_DONE);
	end

	assign arready = !rvalid_reg;
	assign rd_slot = decode_slot(araddr);

	// Read channel; data registered one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			if (rd_slot == SLOT_STATUS) begin
				rdata_reg <= {16'h0000, status_word};
				rresp_reg <= RESP_OKAY;
			end else if (rd_slot == SLOT_NONE) begin
				rdata_reg <= 32'h0000_0000;
				rresp_reg <= RESP_SLVERR;
			end else begin
				rdata_reg <= {16'h0000, cfg_reg[rd_slot]};
				rresp_reg <= RESP_OKAY;
			end
		end else if (rvalid_reg && rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Outputs
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign host_iface_control = cfg_reg[SLOT_HOST_CTRL];
	assign host_iface_config = cfg_reg[SLOT_HOST_CFG];
	assign sync_pulse_length = cfg_reg[SLOT_SYNC_PULSE];
	assign host_iface_ext_config = cfg_reg[SLOT_HOST_EXT_CFG];
	assign station_alias = cfg_reg[SLOT_STATION_ALIAS];
	assign config_loaded = (state_reg == LD_DONE);

	// Defaults stand until the whole area is read
	defaults_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == LD_FETCH) |-> (host_iface_control == RST_HOST_CTRL) && (station_alias == RST_STATION_ALIAS)
		&& (host_iface_config == RST_HOST_CFG) && (sync_pulse_length == RST_SYNC_PULSE))
		else $error("Loaded value released before fetch finished");

	// Alias taken from staged memory word on good checksum
	alias_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == LD_APPLY) && crc_ok |=> station_alias == $past(stage_reg[SLOT_STATION_ALIAS]))
		else $error("Alias not loaded from memory image");

	// Host control and SYNC length follow the image
	host_ctrl_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == LD_APPLY) && crc_ok |=> (host_iface_control == $past(stage_reg[SLOT_HOST_CTRL]))
		&& (sync_pulse_length == $past(stage_reg[SLOT_SYNC_PULSE])))
		else $error("Host control or SYNC length not loaded");

	// Bad checksum keeps host configuration, extended configuration and alias defaults
	crc_bad_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == LD_APPLY) && !crc_ok |=> (host_iface_config == RST_HOST_CFG)
		&& (host_iface_ext_config == RST_HOST_EXT_CFG) && (station_alias == RST_STATION_ALIAS))
		else $error("Defaults lost on checksum mismatch");

	// No second load and no further memory reads
	no_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == LD_DONE) |-> !mem_rd_req ##1 (state_reg == LD_DONE))
		else $error("Loader restarted without power cycle");

	// Reads stay within the word-addressed information area
	word_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mem_rd_req |-> (mem_rd_addr <= EE_SIZE_WORD))
		else $error("Memory address outside word area");

	// Stored checksum captured from word 7
	sum_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		word_valid && (word_idx == FIDX_CHECKSUM) |=> stored_sum_reg == $past(word_data))
		else $error("Checksum word not captured");

	// Wrong size code flags the layout
	size_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		word_valid && (word_idx == FIDX_SIZE) && (word_data != MEM_SIZE_CODE) |=> layout_bad_reg)
		else $error("Size code mismatch not flagged");

	// Wrong mailbox word flags the layout
	mailbox_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
		word_valid && (word_idx >= FIDX_MBX_FIRST) && (word_idx < FIDX_SIZE)
		&& (word_data != expected_word(word_idx)) |=> layout_bad_reg)
		else $error("Mailbox layout mismatch not flagged");

	// Fetch to apply within one cycle of completion
	apply_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fetch_done) |=> (state_reg == LD_APPLY) ##1 (state_reg == LD_DONE))
		else $error("Apply not one cycle after fetch end");

endmodule // scl_loader

// >>> scl_mem_model.sv
/*
 * Behavioural information memory on the far side of the loader's read port.
 * Assumes the tb fills img before each reset and picks the answer lag.
 */
`timescale 1ns/1ps
module scl_mem_model (
	// Clock
	input wire logic aclk,
	// Read port
	input wire logic mem_rd_req,
	input wire logic [9:0] mem_rd_addr,
	output logic mem_rd_ack,
	output logic [15:0] mem_rd_data,
	// Idle cycles before each answer
	input wire logic [1:0] lag
);
	// Word image, one entry per 16-bit word
	logic [15:0] img [0:63];
	int wait_cnt = 0;

	// Layout words past the configuration area
	initial begin
		for (int i = 0; i < 64; i++) begin
			img[i] = 16'h0000;
		end
		img[20] = 16'h1000;
		img[21] = 16'h0100;
		img[22] = 16'h1200;
		img[23] = 16'h0100;
		img[24] = 16'h1000;
		img[25] = 16'h0100;
		img[26] = 16'h1200;
		img[27] = 16'h0100;
		img[62] = 16'h000F;
	end

	// Answer after lag idle cycles; data toggles when not valid so stale values never match
	always @(posedge aclk) begin
		mem_rd_ack <= 1'b0;
		mem_rd_data <= ~mem_rd_data;
		if (mem_rd_req && !mem_rd_ack) begin
			if (wait_cnt >= lag) begin
				mem_rd_ack <= 1'b1;
				mem_rd_data <= img[mem_rd_addr[5:0]];
				wait_cnt <= 0;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule // scl_mem_model

// >>> scl_pkg.sv
/*
 * Shared constants for the power-up configuration loader: register indices,
 * reset values, memory word addresses, expected layout words and checksum setup.
 * Assumes a 16-bit word-addressed information memory and a 32-bit AXI4-Lite bus.
 */
package scl_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [11:0] IDX_STATION_ALIAS = 12'h012;
	localparam logic [11:0] IDX_HOST_CTRL = 12'h140;
	localparam logic [11:0] IDX_HOST_CFG = 12'h150;
	localparam logic [11:0] IDX_HOST_EXT_CFG = 12'h152;
	localparam logic [11:0] IDX_SYNC_PULSE = 12'h982;
	localparam logic [11:0] IDX_LOAD_STATUS = 12'hF00;

	// Hardware defaults, kept when the stored image is not trusted
	localparam logic [15:0] RST_STATION_ALIAS = 16'h0000;
	localparam logic [15:0] RST_HOST_CTRL = 16'h0C05;
	localparam logic [15:0] RST_HOST_CFG = 16'h6603;
	localparam logic [15:0] RST_HOST_EXT_CFG = 16'h0000;
	localparam logic [15:0] RST_SYNC_PULSE = 16'h0064;

	// Slots of the loaded registers, equal to their memory word address
	localparam logic [2:0] SLOT_HOST_CTRL = 3'h0;
	localparam logic [2:0] SLOT_HOST_CFG = 3'h1;
	localparam logic [2:0] SLOT_SYNC_PULSE = 3'h2;
	localparam logic [2:0] SLOT_HOST_EXT_CFG = 3'h3;
	localparam logic [2:0] SLOT_STATION_ALIAS = 3'h4;
	localparam logic [2:0] SLOT_STATUS = 3'h6;
	localparam logic [2:0] SLOT_NONE = 3'h7;

	// Memory word addresses (word addressed, never bytes)
	localparam logic [9:0] EE_CHECKSUM = 10'h007;
	localparam logic [9:0] EE_MBX_BASE_GAP = 10'h00C;
	localparam logic [9:0] EE_SIZE_WORD = 10'h03E;

	// Fetch sequence: words 0..7, mailbox words 14h..1Bh, size word 3Eh
	localparam logic [4:0] FETCH_LAST = 5'h10;
	localparam logic [4:0] FIDX_CHECKSUM = 5'h07;
	localparam logic [4:0] FIDX_MBX_FIRST = 5'h08;
	localparam logic [4:0] FIDX_SIZE = 5'h10;

	// Expected layout words
	localparam logic [15:0] MBX_RX_OFFSET = 16'h1000;
	localparam logic [15:0] MBX_TX_OFFSET = 16'h1200;
	localparam logic [15:0] MBX_SIZE = 16'h0100;
	localparam logic [15:0] MEM_SIZE_CODE = 16'h000F;

	// Checksum: CRC-8 over the first fourteen bytes
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h07;

	// Status register fields
	localparam int unsigned ST_DONE_BIT = 0;
	localparam int unsigned ST_CRC_OK_BIT = 1;
	localparam int unsigned ST_LAYOUT_OK_BIT = 2;
	localparam int unsigned ST_BUSY_BIT = 3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Memory word address of each fetch step
	function automatic logic [9:0] fetch_addr(input logic [4:0] idx);
		if (idx < FIDX_MBX_FIRST) begin
			return {5'h00, idx};
		end else if (idx < FIDX_SIZE) begin
			return {5'h00, idx} + EE_MBX_BASE_GAP;
		end else begin
			return EE_SIZE_WORD;
		end
	endfunction

	// Expected content of a layout word at fetch step 8..16
	function automatic logic [15:0] expected_word(input logic [4:0] idx);
		if (idx == FIDX_SIZE) begin
			return MEM_SIZE_CODE;
		end else if (idx[0]) begin
			return MBX_SIZE;
		end else if (idx[1]) begin
			return MBX_TX_OFFSET;
		end else begin
			return MBX_RX_OFFSET;
		end
	endfunction

	// One byte through the CRC-8
	function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] b);
		logic [7:0] c;
		c = crc ^ b;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

// >>> scl_word_fetch.sv
/*
 * Walks the fixed fetch sequence once after reset, one word read at a time.
 * Assumes the memory port holds mem_rd_ack high for one cycle per request.
 */
`timescale 1ns/1ps
module scl_word_fetch
	import scl_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Memory read port
	output logic mem_rd_req,
	output logic [9:0] mem_rd_addr,
	input wire logic mem_rd_ack,
	input wire logic [15:0] mem_rd_data,
	// Word stream to the loader
	output logic word_valid,
	output logic [4:0] word_idx,
	output logic [15:0] word_data,
	output logic fetch_done
);
	logic [4:0] idx_reg; // Current fetch step
	logic req_reg; // Request outstanding
	logic valid_reg; // One-cycle word strobe
	logic [4:0] out_idx_reg; // Step of delivered word
	logic [15:0] out_data_reg; // Delivered word
	logic done_reg; // Sequence over, restarts only after reset

	// Step sequencing; once done nothing is read again until reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idx_reg <= 5'h00;
			req_reg <= 1'b1;
			done_reg <= 1'b0;
		end else if (req_reg && mem_rd_ack) begin
			if (idx_reg == FETCH_LAST) begin
				req_reg <= 1'b0;
				done_reg <= 1'b1;
			end else begin
				idx_reg <= idx_reg + 5'h01;
			end
		end
	end

	// Word capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_reg <= 1'b0;
			out_idx_reg <= 5'h00;
			out_data_reg <= 16'h0000;
		end else begin
			valid_reg <= req_reg && mem_rd_ack;
			if (req_reg && mem_rd_ack) begin
				out_idx_reg <= idx_reg;
				out_data_reg <= mem_rd_data;
			end
		end
	end

	assign mem_rd_req = req_reg;
	assign mem_rd_addr = fetch_addr(idx_reg);
	assign word_valid = valid_reg;
	assign word_idx = out_idx_reg;
	assign word_data = out_data_reg;
	assign fetch_done = done_reg;
endmodule // scl_word_fetch

// >>> tb.sv
/*
 * Self-checking bench: AXI4-Lite master, power cycles, checksum good and bad.
 * Assumes scl_loader and scl_mem_model; expected bus answers queue in order.
 */
`timescale 1ns/1ps
module tb;
	import scl_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [15:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 0;
	logic awready, wready, bvalid, arready, rvalid, mem_rd_req, mem_rd_ack, config_loaded;
	logic [1:0] bresp, rresp, lag = 0;
	logic [9:0] mem_rd_addr;
	logic [15:0] mem_rd_data, station_alias, host_iface_control, host_iface_config;
	logic [15:0] host_iface_ext_config, sync_pulse_length, d;
	logic [15:0] outs [5], ev [5];
	logic [15:0] dflt [5] = '{RST_STATION_ALIAS, RST_HOST_CTRL, RST_HOST_CFG, RST_HOST_EXT_CFG, RST_SYNC_PULSE};
	logic [11:0] ridx [5] = '{IDX_STATION_ALIAS, IDX_HOST_CTRL, IDX_HOST_CFG, IDX_HOST_EXT_CFG, IDX_SYNC_PULSE};
	logic [33:0] exp_q [$];
	int err_count = 0, check_count = 0;

	scl_loader i_scl_loader (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .station_alias, .host_iface_control,
		.host_iface_config, .host_iface_ext_config, .sync_pulse_length, .config_loaded);
	scl_mem_model i_scl_mem_model (.aclk, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .lag);

	// Clock, 50 ns period
	always #25 aclk = ~aclk;
	always_comb outs = '{station_alias, host_iface_control, host_iface_config, host_iface_ext_config,
		sync_pulse_length};

	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Answer watcher; pre-edge values are the ones the handshake used
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready) begin
			chk({rresp, rdata}, exp_q.pop_front());
		end
		if (bvalid === 1'b1 && bready) begin
			chk({bresp, 32'h0}, exp_q.pop_front());
		end
	end

	function automatic logic [15:0] ba(input logic [11:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// Reference checksum over the fourteen bytes ahead of word 7
	function automatic logic [7:0] crc();
		logic [7:0] c;
		logic [15:0] w;
		c = CRC_INIT;
		for (int i = 0; i < 14; i++) begin
			w = i_scl_mem_model.img[i / 2];
			c ^= i[0] ? w[15:8] : w[7:0];
			repeat (8) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// Read; request released when taken, ready held until the answer is sampled
	task automatic rd(input logic [15:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Write; address and data offered together, each released when taken
	task automatic wr(input logic [15:0] a, input logic [31:0] dw);
		exp_q.push_back({RESP_OKAY, 32'h0});
		awaddr <= a;
		wdata <= dw;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Fresh image then a full power cycle; good picks a matching checksum
	task automatic power(input logic good);
		for (int i = 0; i < 7; i++) i_scl_mem_model.img[i] = 16'($urandom);
		i_scl_mem_model.img[7] = {8'($urandom), good ? crc() : ~crc()};
		lag <= 2'($urandom);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int k = 0; k < 5; k++) chk({18'h0, outs[k]}, {18'h0, dflt[k]});
		chk({33'h0, config_loaded}, 34'h0);
		for (int n = 0; n < 400 && config_loaded !== 1'b1; n++) @(posedge aclk);
		chk({33'h0, config_loaded}, 34'h1);
		for (int k = 0; k < 5; k++) ev[k] = dflt[k];
		if (good) ev = '{i_scl_mem_model.img[4], i_scl_mem_model.img[0], i_scl_mem_model.img[1],
			i_scl_mem_model.img[3], i_scl_mem_model.img[2]};
	endtask

	// Register outputs and bus reads against the expected set
	task automatic regs();
		for (int k = 0; k < 5; k++) begin
			chk({18'h0, outs[k]}, {18'h0, ev[k]});
			rd(ba(ridx[k]), {RESP_OKAY, 16'h0, ev[k]});
		end
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h41fc));
		power(1'b1);
		regs();
		rd(ba(IDX_LOAD_STATUS), {RESP_OKAY, 32'h7});
		i_scl_mem_model.img[4] = ~i_scl_mem_model.img[4];
		i_scl_mem_model.img[7][7:0] = crc();
		regs();
		d = 16'($urandom);
		wr(ba(IDX_STATION_ALIAS), {16'h0, d});
		ev[0] = d;
		regs();
		rd(16'h0004, {RESP_SLVERR, 32'h0});
		rd(16'h0049, {RESP_SLVERR, 32'h0});
		power(1'b0);
		regs();
		rd(ba(IDX_LOAD_STATUS), {RESP_OKAY, 32'h5});
		power(1'b1);
		regs();
		i_scl_mem_model.img[23] = ~MBX_SIZE;
		i_scl_mem_model.img[62] = ~MEM_SIZE_CODE;
		power(1'b1);
		regs();
		rd(ba(IDX_LOAD_STATUS), {RESP_OKAY, 32'h3});
		conclude();
	end

	// Watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge aclk);
		err_count++;
		conclude();
	end
endmodule // tb
